// >>> include/capture_timer_pkg.sv
// Constants for the free-running capture timer: register map, field
// positions, clock-select codes and reload value.
// Assumes a 32-bit AHB-Lite bus with one register per aligned word.
`default_nettype none

package capture_timer_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_COUNT_HI = 8'h00;
    localparam logic [7:0] OFF_COUNT_LO = 8'h04;
    localparam logic [7:0] OFF_SHADOW_HI = 8'h08;
    localparam logic [7:0] OFF_SHADOW_LO = 8'h0c;
    localparam logic [7:0] OFF_CAP1_HI = 8'h10;
    localparam logic [7:0] OFF_CAP1_LO = 8'h14;
    localparam logic [7:0] OFF_CAP2_HI = 8'h18;
    localparam logic [7:0] OFF_CAP2_LO = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_CTL_ONE = 8'h24;
    localparam logic [7:0] OFF_CTL_TWO = 8'h28;
    // timer_control_one fields
    localparam int C1_CAP_IRQ_EN = 7;
    localparam int C1_OVF_IRQ_EN = 5;
    localparam int C1_CAP1_EDGE = 1;
    // timer_control_two fields
    localparam int C2_PWM = 5;
    localparam int C2_ONE_PULSE = 4;
    localparam int C2_CLK_SEL_HI = 3;
    localparam int C2_CLK_SEL_LO = 2;
    localparam int C2_CAP2_EDGE = 1;
    localparam int C2_EXT_EDGE = 0;
    // timer_status_reg fields
    localparam int ST_CAP1 = 7;
    localparam int ST_CAP2 = 6;
    localparam int ST_OVF = 5;
    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
    // Clock-select codes
    localparam logic [1:0] CLK_DIV4 = 2'h0;
    localparam logic [1:0] CLK_DIV2 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    // Prescaler terminal counts
    localparam logic [2:0] PRE_END_DIV2 = 3'h1;
    localparam logic [2:0] PRE_END_DIV4 = 3'h3;
    localparam logic [2:0] PRE_END_DIV8 = 3'h7;
    // Bus codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : capture_timer_pkg

`default_nettype wire

// >>> rtl/capture_timer.sv
// Free-running 16-bit timer with overflow flag and two capture channels,
// byte registers reached over AHB-Lite as word-aligned registers.
// Assumes pins synchronous to clk_in and a single-slave AHB-Lite bus.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Free 16-bit up-counter, high/low byte pair
// - Clock-select 11 picks external clock pin
// - Internal clock divides by 2, 4, 8
// - Low-byte write forces counter to FFFCh
// - Reset loads FFFCh, sole reload value
// - Shadow pair same count, never clears overflow
// - High read buffers low byte until low read
// - Unbuffered low read returns live low byte
// - Wrap FFFFh to 0000h sets overflow flag
// - Overflow interrupt needs enable and unmasked CPU
// - Overflow clear: status read then low access
// - Runs in wait, holds count in halt
// - Edge-select bit picks external clock edge
// - Capture edge latches count, sets flag
// - Edge selects: pin two ctl two, one ctl one
// - One capture enable, unmasked CPU, else pending
// - Capture clear: status read then low access
// - High read blocks channel until low read
// - Newest capture overwrites older value
// - Pulse or PWM mode: channel two only
// - Capture pins always watched, even as outputs
// - Unbonded timer input reads as one
module capture_timer #(
    parameter bit EXT_CLK_BONDED = 1'b1,
    parameter bit CAP1_BONDED = 1'b1,
    parameter bit CAP2_BONDED = 1'b1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Timer pins and CPU state
    input wire logic ext_timer_clock_pin_in,
    input wire logic capture_pin_one_in,
    input wire logic capture_pin_two_in,
    input wire logic cpu_irq_mask_in,
    input wire logic halt_in,
    // Interrupt request
    output logic timer_irq_out
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [15:0] count;
        logic [2:0] pre;
        logic ext_prev;
        logic [1:0] cap_prev;
        logic [7:0] lsb_buf;
        logic lsb_held;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic [1:0] inhibit;
        logic ovf;
        logic [1:0] cf;
        logic arm_ovf;
        logic [1:0] arm_cf;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic irq;
        logic ph_wr;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
    } state_t;

    state_t state_q;
    state_t state_d;
    logic ext_pin;
    logic [1:0] cap_pin;
    logic tick;
    logic [1:0] cap_hit;
    logic addr_ok;
    logic wr_phase;

    // Address match on the word offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Unbonded pins read as one
    assign ext_pin = EXT_CLK_BONDED ? ext_timer_clock_pin_in : 1'b1;
    assign cap_pin[0] = CAP1_BONDED ? capture_pin_one_in : 1'b1;
    assign cap_pin[1] = CAP2_BONDED ? capture_pin_two_in : 1'b1;
    assign addr_ok = hsel_in && hready_in && (htrans_in == capture_timer_pkg::HTRANS_NONSEQ);
    assign wr_phase = state_q.ph_wr;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [1:0] csel;
        logic [2:0] pre_end;
        logic ext_edge;
        logic [1:0] edge_sel;
        state_d = state_q;
        csel = state_q.ctl2[capture_timer_pkg::C2_CLK_SEL_HI:capture_timer_pkg::C2_CLK_SEL_LO];
        pre_end = capture_timer_pkg::PRE_END_DIV4;
        ext_edge = 1'b0;
        edge_sel[0] = state_q.ctl1[capture_timer_pkg::C1_CAP1_EDGE];
        edge_sel[1] = state_q.ctl2[capture_timer_pkg::C2_CAP2_EDGE];
        state_d.rdata = 32'h0000_0000;
        state_d.ph_wr = 1'b0;

        // Prescaler selection; halt freezes both prescaler and counter
        unique case (csel)
            capture_timer_pkg::CLK_DIV2: pre_end = capture_timer_pkg::PRE_END_DIV2;
            capture_timer_pkg::CLK_DIV4: pre_end = capture_timer_pkg::PRE_END_DIV4;
            capture_timer_pkg::CLK_DIV8: pre_end = capture_timer_pkg::PRE_END_DIV8;
            capture_timer_pkg::CLK_EXT: pre_end = capture_timer_pkg::PRE_END_DIV4;
        endcase
        // Edge-select one means rising edge
        if (state_q.ctl2[capture_timer_pkg::C2_EXT_EDGE]) begin
            ext_edge = ext_pin && !state_q.ext_prev;
        end else begin
            ext_edge = !ext_pin && state_q.ext_prev;
        end
        state_d.ext_prev = ext_pin;
        if (csel == capture_timer_pkg::CLK_EXT) begin
            tick = ext_edge && !halt_in;
            state_d.pre = 3'h0;
        end else begin
            tick = (state_q.pre == pre_end) && !halt_in;
            if (!halt_in) begin
                state_d.pre = (state_q.pre == pre_end) ? 3'h0 : state_q.pre + 3'h1;
            end
        end
        if (tick) begin
            state_d.count = state_q.count + 16'h0001;
        end

        // Capture edge detect; pins are watched whatever their port role
        state_d.cap_prev = cap_pin;
        for (int i = 0; i < 2; i++) begin
            cap_hit[i] = (edge_sel[i] ? (cap_pin[i] && !state_q.cap_prev[i])
                                      : (!cap_pin[i] && state_q.cap_prev[i]))
                         && !state_q.inhibit[i];
        end
        // Channel one captures are suppressed in pulse and PWM modes
        if (state_q.ctl2[capture_timer_pkg::C2_ONE_PULSE] || state_q.ctl2[capture_timer_pkg::C2_PWM]) begin
            cap_hit[0] = 1'b0;
        end

        // Write data phase: count and shadow low writes reload; count and capture low writes act as clear step
        if (wr_phase) begin
            if (hit(state_q.ph_addr, capture_timer_pkg::OFF_COUNT_LO)
                || hit(state_q.ph_addr, capture_timer_pkg::OFF_SHADOW_LO)) begin
                state_d.count = capture_timer_pkg::COUNT_RELOAD;
                state_d.pre = 3'h0;
            end
            if (hit(state_q.ph_addr, capture_timer_pkg::OFF_COUNT_LO) && state_q.arm_ovf) begin
                state_d.ovf = 1'b0;
                state_d.arm_ovf = 1'b0;
            end
            if (hit(state_q.ph_addr, capture_timer_pkg::OFF_CAP1_LO) && state_q.arm_cf[0]) begin
                state_d.cf[0] = 1'b0;
                state_d.arm_cf[0] = 1'b0;
            end
            if (hit(state_q.ph_addr, capture_timer_pkg::OFF_CAP2_LO) && state_q.arm_cf[1]) begin
                state_d.cf[1] = 1'b0;
                state_d.arm_cf[1] = 1'b0;
            end
            if (hit(state_q.ph_addr, capture_timer_pkg::OFF_CTL_ONE)) begin
                state_d.ctl1 = hwdata_in[7:0];
            end
            if (hit(state_q.ph_addr, capture_timer_pkg::OFF_CTL_TWO)) begin
                state_d.ctl2 = hwdata_in[7:0];
            end
        end

        // Address phase: reads take effect here, writes wait for data
        if (addr_ok) begin
            state_d.ph_wr = hwrite_in;
            state_d.ph_addr = haddr_in;
        end
        if (addr_ok && !hwrite_in) begin
            unique case (haddr_in)
                capture_timer_pkg::OFF_COUNT_HI, capture_timer_pkg::OFF_SHADOW_HI: begin
                    state_d.rdata[7:0] = state_q.count[15:8];
                    if (!state_q.lsb_held) begin
                        state_d.lsb_buf = state_q.count[7:0];
                        state_d.lsb_held = 1'b1;
                    end
                end
                capture_timer_pkg::OFF_COUNT_LO, capture_timer_pkg::OFF_SHADOW_LO: begin
                    // Live low byte unless a high read buffered it
                    state_d.rdata[7:0] = state_q.lsb_held ? state_q.lsb_buf
                                                          : state_q.count[7:0];
                    state_d.lsb_held = 1'b0;
                    // Shadow low never clears overflow
                    if (hit(haddr_in, capture_timer_pkg::OFF_COUNT_LO) && state_q.arm_ovf) begin
                        state_d.ovf = 1'b0;
                        state_d.arm_ovf = 1'b0;
                    end
                end
                capture_timer_pkg::OFF_CAP1_HI: begin
                    state_d.rdata[7:0] = state_q.cap1[15:8];
                    state_d.inhibit[0] = 1'b1;
                end
                capture_timer_pkg::OFF_CAP2_HI: begin
                    state_d.rdata[7:0] = state_q.cap2[15:8];
                    state_d.inhibit[1] = 1'b1;
                end
                capture_timer_pkg::OFF_CAP1_LO: begin
                    state_d.rdata[7:0] = state_q.cap1[7:0];
                    state_d.inhibit[0] = 1'b0;
                    if (state_q.arm_cf[0]) begin
                        state_d.cf[0] = 1'b0;
                        state_d.arm_cf[0] = 1'b0;
                    end
                end
                capture_timer_pkg::OFF_CAP2_LO: begin
                    state_d.rdata[7:0] = state_q.cap2[7:0];
                    state_d.inhibit[1] = 1'b0;
                    if (state_q.arm_cf[1]) begin
                        state_d.cf[1] = 1'b0;
                        state_d.arm_cf[1] = 1'b0;
                    end
                end
                capture_timer_pkg::OFF_STATUS: begin
                    state_d.rdata[capture_timer_pkg::ST_CAP1] = state_q.cf[0];
                    state_d.rdata[capture_timer_pkg::ST_CAP2] = state_q.cf[1];
                    state_d.rdata[capture_timer_pkg::ST_OVF] = state_q.ovf;
                    // Arm only flags seen set by this read
                    state_d.arm_ovf = state_q.arm_ovf || state_q.ovf;
                    state_d.arm_cf = state_q.arm_cf | state_q.cf;
                end
                capture_timer_pkg::OFF_CTL_ONE: state_d.rdata[7:0] = state_q.ctl1;
                capture_timer_pkg::OFF_CTL_TWO: state_d.rdata[7:0] = state_q.ctl2;
                default: state_d.rdata = 32'h0000_0000;
            endcase
        end

        // Events last so a set beats a same-cycle clear
        if (tick && state_q.count == 16'hffff) begin
            state_d.ovf = 1'b1;
        end
        if (cap_hit[0]) begin
            state_d.cap1 = state_q.count;
            state_d.cf[0] = 1'b1;
        end
        if (cap_hit[1]) begin
            state_d.cap2 = state_q.count;
            state_d.cf[1] = 1'b1;
        end
        // Flags stay pending while masked; request follows when allowed
        state_d.irq = !cpu_irq_mask_in
            && ((state_q.ovf && state_q.ctl1[capture_timer_pkg::C1_OVF_IRQ_EN])
                || ((|state_q.cf) && state_q.ctl1[capture_timer_pkg::C1_CAP_IRQ_EN]));
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= '0;
            state_q.count <= capture_timer_pkg::COUNT_RELOAD;
            state_q.ctl1 <= capture_timer_pkg::CTL_RESET;
            state_q.ctl2 <= capture_timer_pkg::CTL_RESET;
            state_q.ext_prev <= 1'b1;
            state_q.cap_prev <= 2'h3;
        end else begin
            state_q <= state_d;
        end
    end

    // Read data and irq straight from flops; zero wait states, always OKAY
    assign hrdata_out = state_q.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = capture_timer_pkg::HRESP_OKAY;
    assign timer_irq_out = state_q.irq;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic low_wr;
    logic div4_run;
    assign low_wr = wr_phase && (hit(state_q.ph_addr, capture_timer_pkg::OFF_COUNT_LO)
                                 || hit(state_q.ph_addr, capture_timer_pkg::OFF_SHADOW_LO));
    assign div4_run = !halt_in && !low_wr && !wr_phase
        && state_q.ctl2[capture_timer_pkg::C2_CLK_SEL_HI:capture_timer_pkg::C2_CLK_SEL_LO]
           == capture_timer_pkg::CLK_DIV4;

    sequence s_div4_start;
        tick && div4_run;
    endsequence
    sequence s_div4_gap;
        div4_run [*4];
    endsequence

    property p_div4;
        @(posedge clk_in) disable iff (!reset_n_in)
        s_div4_start ##1 s_div4_gap |-> tick;
    endproperty
    a_div4: assert property (p_div4) else $error("divide-by-4 period wrong");

    property p_reload;
        @(posedge clk_in) disable iff (!reset_n_in)
        low_wr |=> state_q.count == 16'hfffc;
    endproperty
    a_reload: assert property (p_reload) else $error("low write did not reload");

    property p_wrap;
        @(posedge clk_in) disable iff (!reset_n_in)
        tick && state_q.count == 16'hffff && !low_wr |=> state_q.ovf && state_q.count == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not set overflow");

    property p_ovf_clear;
        @(posedge clk_in) disable iff (!reset_n_in)
        $fell(state_q.ovf) |-> $past(state_q.arm_ovf);
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow cleared unarmed");

    property p_halt;
        @(posedge clk_in) disable iff (!reset_n_in)
        halt_in && !low_wr |=> $stable(state_q.count);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved in halt");

    property p_capture;
        @(posedge clk_in) disable iff (!reset_n_in)
        cap_hit[1] |=> state_q.cap2 == $past(state_q.count) && state_q.cf[1];
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    property p_inhibit;
        @(posedge clk_in) disable iff (!reset_n_in)
        state_q.inhibit[0] |=> $stable(state_q.cap1);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("capture while blocked");

    property p_pulse_mode;
        @(posedge clk_in) disable iff (!reset_n_in)
        state_q.ctl2[capture_timer_pkg::C2_ONE_PULSE] |=> !$rose(state_q.cf[0]);
    endproperty
    a_pulse_mode: assert property (p_pulse_mode) else $error("channel one in pulse mode");

    property p_irq;
        @(posedge clk_in) disable iff (!reset_n_in)
        state_q.ovf && state_q.ctl1[capture_timer_pkg::C1_OVF_IRQ_EN] && !cpu_irq_mask_in
        |=> timer_irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("overflow irq missing");

    property p_buffer;
        @(posedge clk_in) disable iff (!reset_n_in)
        state_q.lsb_held && addr_ok && !hwrite_in && haddr_in == capture_timer_pkg::OFF_COUNT_HI
        |=> $stable(state_q.lsb_buf);
    endproperty
    a_buffer: assert property (p_buffer) else $error("low buffer overwritten");

endmodule : capture_timer

`default_nettype wire

// >>> test/free_running_timer_input_capture_bench.sv
// Self-checking bench for the capture timer over AHB-Lite.
// Assumes zero-wait slave; halt freezes the count for exact checks.
`timescale 1ns/10ps
`default_nettype none

module free_running_timer_input_capture_bench;
    typedef struct {logic [1:0] code; logic edge_sel; int lo; int hi;} row_t;
    // Clock code, ext edge, window of cycles from reload to overflow irq
    row_t rows[5] = '{'{2'h0, 1'b0, 13, 20}, '{2'h1, 1'b0, 7, 12},
        '{2'h2, 1'b0, 25, 36}, '{2'h3, 1'b1, 24, 44}, '{2'h3, 1'b0, 24, 44}};
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic mask = 1'b0;
    logic halt = 1'b1;
    logic lvl1 = 1'b1;
    logic lvl2 = 1'b1;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hready, hresp, irq, ext_pin, pin1, pin2;
    logic [7:0] keep_hi, keep_lo;
    logic [7:0] hi_a[2] = '{capture_timer_pkg::OFF_COUNT_HI, capture_timer_pkg::OFF_SHADOW_HI};
    logic [7:0] lo_a[2] = '{capture_timer_pkg::OFF_COUNT_LO, capture_timer_pkg::OFF_SHADOW_LO};
    int n_mismatch = 0;
    int samples_checked = 0;
    int wait_n;

    capture_timer dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hready_in(hready),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .ext_timer_clock_pin_in(ext_pin), .capture_pin_one_in(pin1),
        .capture_pin_two_in(pin2), .cpu_irq_mask_in(mask), .halt_in(halt),
        .timer_irq_out(irq));
    pin_source src (.clk_in(clk_in), .reset_n_in(reset_n_in), .cap_one_level_in(lvl1),
        .cap_two_level_in(lvl2), .ext_clock_out(ext_pin), .cap_one_out(pin1),
        .cap_two_out(pin2));

    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;

    // One single transfer; waits on hready, data taken at the closing edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= capture_timer_pkg::HTRANS_NONSEQ;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_in); while (hready !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask : rdchk

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // Watchdog: whole run needs well under a thousand cycles
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // Halted from reset, so the reload value must still stand
        rdchk("count_hi", capture_timer_pkg::OFF_COUNT_HI, 32'hff);
        rdchk("count_lo", capture_timer_pkg::OFF_COUNT_LO, 32'hfc);
        rdchk("ctl_two", capture_timer_pkg::OFF_CTL_TWO, 32'h0);
        rdchk("unmapped", 8'h3c, 32'h0);
        halt <= 1'b0;
        bus(1'b1, capture_timer_pkg::OFF_CTL_ONE, 32'h20);
        // Table: every clock code, reload, time to overflow, then clear
        foreach (rows[i]) begin
            bus(1'b1, capture_timer_pkg::OFF_CTL_TWO, 32'({rows[i].code, 1'b0, rows[i].edge_sel}));
            bus(1'b1, capture_timer_pkg::OFF_COUNT_LO, 32'h0);
            wait_n = 0;
            while (irq !== 1'b1 && wait_n < 60) begin
                @(posedge clk_in);
                wait_n++;
            end
            check("ovf_time", 1, wait_n >= rows[i].lo && wait_n <= rows[i].hi);
            rdchk("status_ovf", capture_timer_pkg::OFF_STATUS, 32'h20);
            bus(1'b0, capture_timer_pkg::OFF_COUNT_LO, 32'h0);
            repeat (2) @(posedge clk_in);
            check("irq_cleared", 0, irq);
        end
        // Masked overflow stays pending; shadow low never clears the flag
        bus(1'b1, capture_timer_pkg::OFF_CTL_TWO, 32'h4);
        mask <= 1'b1;
        bus(1'b1, capture_timer_pkg::OFF_COUNT_LO, 32'h0);
        repeat (20) @(posedge clk_in);
        check("irq_masked", 0, irq);
        mask <= 1'b0;
        repeat (2) @(posedge clk_in);
        check("irq_pending", 1, irq);
        rdchk("status_set", capture_timer_pkg::OFF_STATUS, 32'h20);
        bus(1'b0, capture_timer_pkg::OFF_SHADOW_LO, 32'h0);
        rdchk("shadow_keeps", capture_timer_pkg::OFF_STATUS, 32'h20);
        bus(1'b0, capture_timer_pkg::OFF_COUNT_LO, 32'h0);
        rdchk("ovf_clear", capture_timer_pkg::OFF_STATUS, 32'h0);
        // Buffered low byte survives counting and a repeated high read
        for (int p = 0; p < 2; p++) begin
            halt <= 1'b1;
            bus(1'b0, lo_a[p], 32'h0);
            keep_lo = rd[7:0];
            bus(1'b0, hi_a[p], 32'h0);
            halt <= 1'b0;
            repeat (13) @(posedge clk_in);
            halt <= 1'b1;
            bus(1'b0, hi_a[p], 32'h0);
            rdchk("buffered_lo", lo_a[p], {24'h0, keep_lo});
            bus(1'b0, lo_a[p], 32'h0);
            check("live_lo_moved", 1, rd[7:0] !== keep_lo);
        end
        // Channel one on rising edge; a fall on pin one is not its edge
        bus(1'b0, capture_timer_pkg::OFF_COUNT_HI, 32'h0);
        keep_hi = rd[7:0];
        bus(1'b0, capture_timer_pkg::OFF_COUNT_LO, 32'h0);
        keep_lo = rd[7:0];
        bus(1'b1, capture_timer_pkg::OFF_CTL_ONE, 32'h82);
        lvl1 <= 1'b0;
        repeat (4) @(posedge clk_in);
        check("fall_ignored", 0, irq);
        lvl1 <= 1'b1;
        repeat (4) @(posedge clk_in);
        check("cap_irq", 1, irq);
        rdchk("status_cap1", capture_timer_pkg::OFF_STATUS, 32'h80);
        rdchk("cap1_hi", capture_timer_pkg::OFF_CAP1_HI, {24'h0, keep_hi});
        // Edge while the channel is blocked after its high read
        lvl1 <= 1'b0;
        halt <= 1'b0;
        repeat (10) @(posedge clk_in);
        halt <= 1'b1;
        lvl1 <= 1'b1;
        repeat (4) @(posedge clk_in);
        rdchk("cap1_lo", capture_timer_pkg::OFF_CAP1_LO, {24'h0, keep_lo});
        rdchk("status_none", capture_timer_pkg::OFF_STATUS, 32'h0);
        // Two falls on pin two: the newer count overwrites the older
        for (int k = 0; k < 2; k++) begin
            halt <= 1'b0;
            repeat (6) @(posedge clk_in);
            halt <= 1'b1;
            bus(1'b0, capture_timer_pkg::OFF_COUNT_HI, 32'h0);
            keep_hi = rd[7:0];
            bus(1'b0, capture_timer_pkg::OFF_COUNT_LO, 32'h0);
            keep_lo = rd[7:0];
            lvl2 <= 1'b0;
            repeat (4) @(posedge clk_in);
            lvl2 <= 1'b1;
            repeat (4) @(posedge clk_in);
        end
        rdchk("cap2_hi", capture_timer_pkg::OFF_CAP2_HI, {24'h0, keep_hi});
        rdchk("cap2_lo", capture_timer_pkg::OFF_CAP2_LO, {24'h0, keep_lo});
        // Pulse and PWM modes leave channel one without captures
        for (int m = 4; m < 6; m++) begin
            bus(1'b1, capture_timer_pkg::OFF_CTL_TWO, (32'h1 << m) | 32'h4);
            lvl1 <= 1'b0;
            repeat (4) @(posedge clk_in);
            lvl1 <= 1'b1;
            repeat (4) @(posedge clk_in);
            bus(1'b0, capture_timer_pkg::OFF_STATUS, 32'h0);
            check("no_cap1", 0, rd[7]);
        end
        check("hresp", 0, hresp);
        check("hready", 1, hready);
        close_out();
    end
endmodule : free_running_timer_input_capture_bench

`default_nettype wire

// >>> test/pin_source.sv
// Far-side pin model: external timer clock and the two capture pins.
// Assumes the bench asks for capture levels; the timer clock runs free.
`timescale 1ns/10ps
`default_nettype none

module pin_source (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Requested capture pin levels
    input wire logic cap_one_level_in,
    input wire logic cap_two_level_in,
    // Pins into the timer
    output logic ext_clock_out,
    output logic cap_one_out,
    output logic cap_two_out
);
    logic [1:0] phase_q;

    // Toggle every 4 cycles, so active edges sit 8 cycles apart
    // Capture pins only move just after an edge, never glitching
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_q <= 2'h0;
            ext_clock_out <= 1'b0;
            cap_one_out <= 1'b1; // Idle high like a pulled-up input
            cap_two_out <= 1'b1; // No false fall once reset lifts
        end else begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h3) begin
                ext_clock_out <= ~ext_clock_out;
            end
            cap_one_out <= cap_one_level_in;
            cap_two_out <= cap_two_level_in;
        end
    end
endmodule : pin_source

`default_nettype wire
